// [rtl/hvs_pkg.sv]
// Constants, tables and types for the high-voltage shutdown sequencer
package hvs_pkg;

    // ==========================================================
    // Clock, tick and sample format
    localparam int HVS_CLK_MHZ   = 20;                      // System clock rate
    localparam int HVS_TICK_US   = 10;                      // Timer tick period in microseconds
    localparam int HVS_TICK_CYC  = HVS_TICK_US * HVS_CLK_MHZ; // Cycles per timer tick
    localparam int HVS_SMP_W     = 12;                      // Sense sample width, units of 10 mV
    localparam int HVS_TIME_W    = 17;                      // Timer width in ticks

    // ==========================================================
    // Hysteresis of 1.5 percent as a ratio against 1000
    localparam logic [21:0] HVS_HYST_LO  = 22'h00_03D9;     // 985
    localparam logic [21:0] HVS_HYST_HI  = 22'h00_03F7;     // 1015
    localparam logic [21:0] HVS_HYST_DEN = 22'h00_03E8;     // 1000

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] HVS_REG_BAT_THR  = 8'h00;
    localparam logic [7:0] HVS_REG_IGN_THR  = 8'h04;
    localparam logic [7:0] HVS_REG_BAT_TIME = 8'h08;
    localparam logic [7:0] HVS_REG_IGN_TIME = 8'h0C;
    localparam logic [7:0] HVS_REG_FAULT    = 8'h10;
    localparam logic [7:0] HVS_REG_STATUS   = 8'h14;

    // Fault bit positions
    localparam int HVS_FLT_OV  = 0;
    localparam int HVS_FLT_UV  = 1;
    localparam int HVS_FLT_OFF = 2;

    // Turn-off code that selects rising-edge trigger mode
    localparam logic [3:0] HVS_EDGE_MODE_CODE = 4'h9;

    // ==========================================================
    // Threshold tables, 10 mV units, entry 15 first, entry 0 last
    localparam logic [15:0][11:0] HVS_OV_TAB = {
        12'h528, 12'h4B0, 12'h5F3, 12'h586, 12'h384, 12'h318, 12'h44C, 12'h3DE,
        12'h898, 12'h7BC, 12'hB0D, 12'h9AB, 12'h6BA, 12'h630, 12'h672, 12'h708};
    localparam logic [15:0][11:0] HVS_UV_TAB = {
        12'h44C, 12'h48D, 12'h3DE, 12'h412, 12'h528, 12'h556, 12'h4B0, 12'h4D6,
        12'h2B7, 12'h2EB, 12'h258, 12'h289, 12'h384, 12'h3AF, 12'h320, 12'h34B};
    localparam logic [15:0][11:0] HVS_ON_TAB = {
        12'h318, 12'h34B, 12'h384, 12'h3AF, 12'h3DE, 12'h5F3, 12'h7BC, 12'h9AB,
        12'h12C, 12'h14A, 12'h1C2, 12'h1DD, 12'h258, 12'h289, 12'h2BC, 12'h2EB};
    localparam logic [15:0][11:0] HVS_OFF_TAB = {
        12'h34B, 12'h318, 12'h3AF, 12'h384, 12'h5F3, 12'h3DE, 12'h000, 12'h7BC,
        12'h14A, 12'h12C, 12'h1DD, 12'h1C2, 12'h289, 12'h258, 12'h28A, 12'h2B7};

    // ==========================================================
    // Timing tables in ticks, entry 7 first, entry 0 last
    localparam logic [7:0][16:0] HVS_BAT_HOLD_TAB = {
        17'h0_0007, 17'h0_07D0, 17'h0_0FA0, 17'h0_1770,
        17'h0_1F40, 17'h0_2710, 17'h0_3A98, 17'h0_4E20};
    localparam logic [7:0][16:0] HVS_BAT_DELAY_TAB = {
        17'h0_0007, 17'h0_1388, 17'h0_2710, 17'h0_4E20,
        17'h0_9C40, 17'h1_3880, 17'h1_86A0, 17'h1_D4C0};
    localparam logic [7:0][16:0] HVS_IGN_HOLD_TAB = {
        17'h0_0007, 17'h0_4E20, 17'h0_2710, 17'h0_1388,
        17'h0_0FA0, 17'h0_0BB8, 17'h0_07D0, 17'h0_03E8};
    localparam logic [7:0][16:0] HVS_IGN_DELAY_TAB = {
        17'h0_0007, 17'h1_D4C0, 17'h1_86A0, 17'h1_3880,
        17'h0_9C40, 17'h0_4E20, 17'h0_1388, 17'h0_2710};

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        HVS_CH_IDLE  = 2'b00,
        HVS_CH_DELAY = 2'b01,
        HVS_CH_OFF   = 2'b10,
        HVS_CH_HOLD  = 2'b11
    } hvsChState_t;

    typedef struct packed {
        logic [11:0] battery;                               // Battery sample, 10 mV units
        logic [11:0] ignition;                              // Ignition sample, 10 mV units
    } hvsSense_t;

    typedef struct packed {
        logic [3:0] batOv;
        logic [3:0] batUv;
        logic [3:0] ignOn;
        logic [3:0] ignOff;
        logic [2:0] batHold;
        logic [2:0] batDelay;
        logic [2:0] ignHold;
        logic [2:0] ignDelay;
    } hvsCfg_t;

    // All codes zero select the power-on defaults
    localparam hvsCfg_t HVS_CFG_RST = '0;

endpackage : hvs_pkg

// [rtl/hvs_sequencer.sv]
// High-voltage shutdown sequencer with APB register access
`timescale 1ns/1ps
module hvs_sequencer #(
    parameter int TICK_CYCLES = hvs_pkg::HVS_TICK_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire hvs_pkg::hvsSense_t sense,
    output logic                   supplyOffN,
    output logic                   powerLossWarningN,
    output logic                   resetOutN,
    output logic                   internalRegulatorEn
);
    import hvs_pkg::*;

    // ==========================================================
    // Helper functions
    // Address decode shared by write enable and error answer; the read multiplexer decodes paddr itself
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == HVS_REG_BAT_THR) || (a == HVS_REG_IGN_THR) || (a == HVS_REG_BAT_TIME) ||
                   (a == HVS_REG_IGN_TIME) || (a == HVS_REG_FAULT) || (a == HVS_REG_STATUS);
    endfunction

    // Comparator with hysteresis; over selects rising-threshold sense
    function automatic logic hystCmp(input logic act, input logic [11:0] s,
                                     input logic [11:0] thr, input logic over);
        logic [21:0] sScaled;
        logic [21:0] tLo;
        logic [21:0] tHi;
        sScaled = {10'd0, s} * HVS_HYST_DEN;
        tLo     = {10'd0, thr} * HVS_HYST_LO;
        tHi     = {10'd0, thr} * HVS_HYST_HI;
        if (over) begin
            hystCmp = act ? !(sScaled < tLo) : (s > thr);
        end else begin
            hystCmp = act ? !(sScaled > tHi) : (s < thr);
        end
    endfunction

    // ==========================================================
    // Declarations
    hvsCfg_t                 cfg_r;
    logic [2:0]              fault_r;
    logic                    ovAct_r;
    logic                    uvAct_r;
    logic                    onAct_r;
    logic                    offAct_r;
    logic                    onActPrev_r;
    logic                    regOn_r;
    logic [15:0]             tickCnt_r;
    logic                    tick;
    hvsChState_t             chState_r [2];
    logic [HVS_TIME_W-1:0]   chCnt_r   [2];
    logic [1:0]              trig;
    logic [HVS_TIME_W-1:0]   delayTicks [2];
    logic [HVS_TIME_W-1:0]   holdTicks  [2];
    logic                    edgeMode;
    logic                    offIgnored;
    logic                    anyOff;
    logic                    anyActive;
    logic                    wrEn;
    logic                    rdSetup;
    logic [2:0]              faultSet;
    logic [11:0]             thrOv;
    logic [11:0]             thrUv;
    logic [11:0]             thrOn;
    logic [11:0]             thrOff;
    logic [31:0]             rdData;

    // ==========================================================
    // APB slave: zero wait states, read data captured in setup
    assign wrEn    = psel && penable && pwrite && isMapped(paddr);
    assign rdSetup = psel && !penable && !pwrite;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !isMapped(paddr);

    // Read multiplexer
    always_comb begin
        rdData = 32'h0000_0000;
        unique case (paddr)
            HVS_REG_BAT_THR:  rdData[7:0] = {cfg_r.batUv, cfg_r.batOv};
            HVS_REG_IGN_THR:  rdData[7:0] = {cfg_r.ignOff, cfg_r.ignOn};
            HVS_REG_BAT_TIME: rdData[6:0] = {cfg_r.batDelay, 1'b0, cfg_r.batHold};
            HVS_REG_IGN_TIME: rdData[6:0] = {cfg_r.ignDelay, 1'b0, cfg_r.ignHold};
            HVS_REG_FAULT:    rdData[2:0] = fault_r;
            HVS_REG_STATUS:   rdData[11:0] = {chState_r[1], chState_r[0], edgeMode, regOn_r,
                                              powerLossWarningN, supplyOffN,
                                              offAct_r, onAct_r, uvAct_r, ovAct_r};
            default:          rdData = 32'h0000_0000;
        endcase
    end

    // Read data register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (rdSetup) begin
            prdata <= rdData;
        end
    end

    // Configuration registers; zero codes are the defaults
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r <= HVS_CFG_RST;
        end else if (wrEn) begin
            unique case (paddr)
                HVS_REG_BAT_THR: begin
                    cfg_r.batOv <= pwdata[3:0];
                    cfg_r.batUv <= pwdata[7:4];
                end
                HVS_REG_IGN_THR: begin
                    cfg_r.ignOn  <= pwdata[3:0];
                    cfg_r.ignOff <= pwdata[7:4];
                end
                HVS_REG_BAT_TIME: begin
                    cfg_r.batHold  <= pwdata[2:0];
                    cfg_r.batDelay <= pwdata[6:4];
                end
                HVS_REG_IGN_TIME: begin
                    cfg_r.ignHold  <= pwdata[2:0];
                    cfg_r.ignDelay <= pwdata[6:4];
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Threshold and timing lookup
    assign thrOv  = HVS_OV_TAB[cfg_r.batOv];
    assign thrUv  = HVS_UV_TAB[cfg_r.batUv];
    assign thrOn  = HVS_ON_TAB[cfg_r.ignOn];
    assign thrOff = HVS_OFF_TAB[cfg_r.ignOff];
    assign edgeMode   = (cfg_r.ignOff == HVS_EDGE_MODE_CODE);
    assign offIgnored = edgeMode || (thrOff > thrOn);

    assign delayTicks[0] = HVS_BAT_DELAY_TAB[cfg_r.batDelay];
    assign holdTicks[0]  = HVS_BAT_HOLD_TAB[cfg_r.batHold];
    assign delayTicks[1] = HVS_IGN_DELAY_TAB[cfg_r.ignDelay];
    assign holdTicks[1]  = HVS_IGN_HOLD_TAB[cfg_r.ignHold];

    // Timer tick divider
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tickCnt_r <= 16'h0000;
        end else if (tickCnt_r == 16'(TICK_CYCLES - 1)) begin
            tickCnt_r <= 16'h0000;
        end else begin
            tickCnt_r <= tickCnt_r + 16'h0001;
        end
    end
    assign tick = (tickCnt_r == 16'(TICK_CYCLES - 1));

    // ==========================================================
    // Hysteresis comparators
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ovAct_r     <= 1'b0;
            uvAct_r     <= 1'b0;
            onAct_r     <= 1'b0;
            offAct_r    <= 1'b0;
            onActPrev_r <= 1'b0;
        end else begin
            ovAct_r     <= hystCmp(ovAct_r, sense.battery, thrOv, 1'b1);
            uvAct_r     <= hystCmp(uvAct_r, sense.battery, thrUv, 1'b0);
            onAct_r     <= hystCmp(onAct_r, sense.ignition, thrOn, 1'b1);
            offAct_r    <= hystCmp(offAct_r, sense.ignition, thrOff, 1'b0);
            onActPrev_r <= onAct_r;
        end
    end

    // Regulator enable: waits for a valid ignition condition
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            regOn_r <= 1'b0;
        end else if (!regOn_r) begin
            regOn_r <= edgeMode ? (onAct_r && !onActPrev_r) : onAct_r;
        end
    end

    // ==========================================================
    // Shutdown triggers: battery window, ignition turn-off
    assign trig[0] = ovAct_r || uvAct_r;
    assign trig[1] = regOn_r && offAct_r && !offIgnored;

    // Per-channel delay/hold sequencers
    for (genvar ch = 0; ch < 2; ch++) begin : gCh
        always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
                chState_r[ch] <= HVS_CH_IDLE;
                chCnt_r[ch]   <= '0;
            end else begin
                unique case (chState_r[ch])
                    HVS_CH_IDLE: begin
                        chCnt_r[ch] <= '0;
                        if (trig[ch]) begin
                            chState_r[ch] <= HVS_CH_DELAY;
                        end
                    end
                    HVS_CH_DELAY: begin
                        if (!trig[ch]) begin
                            chState_r[ch] <= HVS_CH_IDLE;
                        end else if (tick) begin
                            if (chCnt_r[ch] + 1'b1 >= delayTicks[ch]) begin
                                chState_r[ch] <= HVS_CH_OFF;
                                chCnt_r[ch]   <= '0;
                            end else begin
                                chCnt_r[ch] <= chCnt_r[ch] + 1'b1;
                            end
                        end
                    end
                    HVS_CH_OFF: begin
                        chCnt_r[ch] <= '0;
                        if (!trig[ch]) begin
                            chState_r[ch] <= HVS_CH_HOLD;
                        end
                    end
                    HVS_CH_HOLD: begin
                        if (trig[ch]) begin
                            chState_r[ch] <= HVS_CH_OFF;
                            chCnt_r[ch]   <= '0;
                        end else if (tick) begin
                            if (chCnt_r[ch] + 1'b1 >= holdTicks[ch]) begin
                                chState_r[ch] <= HVS_CH_IDLE;
                                chCnt_r[ch]   <= '0;
                            end else begin
                                chCnt_r[ch] <= chCnt_r[ch] + 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Fault detection register: set wins over write-one-to-clear
    assign faultSet[HVS_FLT_OV]  = (chState_r[0] == HVS_CH_IDLE) && trig[0] && ovAct_r;
    assign faultSet[HVS_FLT_UV]  = (chState_r[0] == HVS_CH_IDLE) && trig[0] && uvAct_r;
    assign faultSet[HVS_FLT_OFF] = (chState_r[1] == HVS_CH_IDLE) && trig[1];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fault_r <= 3'h0;
        end else begin
            fault_r <= (fault_r & ~((wrEn && paddr == HVS_REG_FAULT) ? pwdata[2:0] : 3'h0))
                       | faultSet;
        end
    end

    // ==========================================================
    // Output drivers
    assign anyOff    = (chState_r[0] inside {HVS_CH_OFF, HVS_CH_HOLD}) ||
                       (chState_r[1] inside {HVS_CH_OFF, HVS_CH_HOLD});
    assign anyActive = (chState_r[0] != HVS_CH_IDLE) || (chState_r[1] != HVS_CH_IDLE) ||
                       trig[0] || trig[1];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            supplyOffN          <= 1'b0;
            resetOutN           <= 1'b0;
            powerLossWarningN   <= 1'b1;
            internalRegulatorEn <= 1'b0;
        end else begin
            supplyOffN          <= regOn_r && !anyOff;
            resetOutN           <= regOn_r && !anyOff;
            powerLossWarningN   <= !(regOn_r && anyActive);
            internalRegulatorEn <= regOn_r;
        end
    end

endmodule // hvs_sequencer

// [tb/hvs_seq_props.sv]
// Port-level assertions for the shutdown sequencer
`timescale 1ns/1ps
module hvs_seq_props #(
    parameter int TICK_CYCLES = 2
) (
    input wire logic               clk_sys,
    input wire logic               sys_rst,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pready,
    input wire hvs_pkg::hvsSense_t sense,
    input wire logic               supplyOffN,
    input wire logic               powerLossWarningN,
    input wire logic               resetOutN,
    input wire logic               internalRegulatorEn
);
    import hvs_pkg::*;
    localparam int HOLD_MIN = 6 * TICK_CYCLES;
    logic [15:0] offRun_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Cycles with supply-off low, saturating; reset starts it full
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            offRun_r <= 16'hFFFF;
        end else if (supplyOffN) begin
            offRun_r <= 16'h0000;
        end else if (offRun_r != 16'hFFFF) begin
            offRun_r <= offRun_r + 16'h0001;
        end
    end

    // ==========================================================
    // Assertions and covers
    a_reset_tracks: assert property (resetOutN == supplyOffN)
        else $error("reset output differs from supply-off");
    a_warn_first: assert property ($fell(supplyOffN) |-> $past(powerLossWarningN) == 1'b0)
        else $error("supply-off fell without warning first");
    a_reg_gate: assert property (!internalRegulatorEn |-> !supplyOffN && powerLossWarningN)
        else $error("outputs released while regulator off");
    a_reg_sticky: assert property (internalRegulatorEn |=> internalRegulatorEn)
        else $error("regulator dropped after enable");
    a_ov_warn: assert property ((internalRegulatorEn && sense.battery > 12'hB0D) [*4] |-> !powerLossWarningN)
        else $error("no warning on battery above every limit");
    a_uv_warn: assert property ((internalRegulatorEn && sense.battery < 12'h258) [*4] |-> !powerLossWarningN)
        else $error("no warning on battery below every limit");
    a_hold_min: assert property ($rose(supplyOffN) |-> $past(offRun_r) >= HOLD_MIN)
        else $error("supply-off released before hold time");
    a_warn_release: assert property ($rose(powerLossWarningN) |-> supplyOffN)
        else $error("warning released while supply-off low");
    a_apb_ready: assert property (psel |-> pready == penable)
        else $error("access phase without ready");
    c_shut: cover property ($fell(supplyOffN));
    c_release: cover property ($rose(supplyOffN) && powerLossWarningN);
    c_abort: cover property ($rose(powerLossWarningN) && $past(supplyOffN));
endmodule // hvs_seq_props

bind hvs_sequencer hvs_seq_props #(
    .TICK_CYCLES(TICK_CYCLES)
) i_hvs_seq_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pready(pready), .sense(sense), .supplyOffN(supplyOffN),
    .powerLossWarningN(powerLossWarningN), .resetOutN(resetOutN),
    .internalRegulatorEn(internalRegulatorEn)
);

// [tb/hvs_supply_model.sv]
// Battery and ignition source model with load-off counting
`timescale 1ns/1ps
module hvs_supply_model (
    input  wire logic               clk_sys,
    input  wire logic [11:0]        batLevel,
    input  wire logic [11:0]        ignLevel,
    input  wire logic               supplyOffN,
    output hvs_pkg::hvsSense_t      sense,
    output int                      offEvents
);
    import hvs_pkg::*;
    logic offSeen_r = 1'b0;

    initial offEvents = 0;

    // Converter stage: one cycle from level to sample
    always @(posedge clk_sys) begin
        sense <= {batLevel, ignLevel};
    end

    // Loads switched off by a falling supply-off
    always @(posedge clk_sys) begin
        offSeen_r <= supplyOffN;
        if (offSeen_r === 1'b1 && supplyOffN === 1'b0) begin
            offEvents <= offEvents + 1;
        end
    end
endmodule // hvs_supply_model

// [tb/tb.sv]
// Self-checking bench for the high-voltage shutdown sequencer
`timescale 1ns/1ps
module tb;
    import hvs_pkg::*;
    localparam int T = 2;
    logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic        supplyOffN, powerLossWarningN, resetOutN, internalRegulatorEn;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] bat, ign, thr;
    hvsSense_t   sense;
    int          offEvents, error_cnt, total_checks, cyc, seed, n;

    hvs_sequencer #(.TICK_CYCLES(T)) i_hvs_sequencer (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sense(sense), .supplyOffN(supplyOffN), .powerLossWarningN(powerLossWarningN),
        .resetOutN(resetOutN), .internalRegulatorEn(internalRegulatorEn));
    hvs_supply_model i_hvs_supply_model (
        .clk_sys(clk_sys), .batLevel(bat), .ignLevel(ign), .supplyOffN(supplyOffN),
        .sense(sense), .offEvents(offEvents));

    // Clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // APB transfer: setup, then access until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        // Access phase lasts until ready; only the cycle guard ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task set_sense(input logic [11:0] b, input logic [11:0] i);
        @(posedge clk_sys);
        bat <= b;
        ign <= i;
    endtask

    // Cycles until output sel (0 warn, 1 supply-off, 2 regulator) reaches lvl
    task wait_for(input int sel, input logic lvl, input int lim, output int cnt);
        logic v;
        cnt = 0;
        do begin
            @(posedge clk_sys);
            #1;
            v = sel == 0 ? powerLossWarningN : sel == 1 ? supplyOffN : internalRegulatorEn;
            cnt++;
        end while (v !== lvl && cnt < lim);
    endtask

    // Trigger, hysteresis band, release, then fault record and clear
    task fault_run(input logic [11:0] b, i, hb, hi, input int idx);
        set_sense(b, i);
        wait_for(0, 1'h0, 8, n);
        chk(n <= 5, 1'h1);
        wait_for(1, 1'h0, 40, n);
        chk(n >= 6 * T && n <= 8 * T + 2, 1'h1);
        set_sense(hb, hi);
        wait_for(1, 1'h1, 40, n);
        chk(n, 40);
        set_sense(12'h4B0, 12'h2EC);
        wait_for(1, 1'h1, 60, n);
        chk(n >= 6 * T && n <= 8 * T + 5, 1'h1);
        apb(1'h0, HVS_REG_FAULT, 32'h0000_0000);
        chk(rd, 32'h0000_0001 << idx);
        apb(1'h1, HVS_REG_FAULT, 32'h0000_0007);
        apb(1'h0, HVS_REG_FAULT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {error_cnt, total_checks, cyc} = '0;
        seed = 51;
        sys_rst = 1'h1;
        bat = 12'h4B0;
        ign = 12'h2EB;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'h0;
        // Ignition exactly at turn-on level keeps regulator off
        wait_for(2, 1'h1, 10, n);
        chk(n, 10);
        chk(supplyOffN, 1'h0);
        for (int a = 0; a < 5; a++) begin
            apb(1'h0, 8'(a * 4), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
        apb(1'h0, 8'h18, 32'h0000_0000);
        chk(err, 1'h1);
        chk(rd, 32'h0000_0000);
        set_sense(12'h4B0, 12'h2EC);
        wait_for(1, 1'h1, 8, n);
        chk(n <= 6, 1'h1);
        // Default thresholds and long default delay, cause gone early
        set_sense(12'h708, 12'h2EC);
        wait_for(0, 1'h0, 6, n);
        chk(n, 6);
        set_sense(12'h709, 12'h2EC);
        wait_for(0, 1'h0, 8, n);
        chk(n <= 5, 1'h1);
        wait_for(1, 1'h0, 300, n);
        chk(n, 300);
        // Cause gone during delay: warning back, no supply-off, fault kept
        set_sense(12'h4B0, 12'h2EC);
        wait_for(0, 1'h1, 8, n);
        chk(n <= 5, 1'h1);
        chk(supplyOffN, 1'h1);
        apb(1'h0, HVS_REG_FAULT, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'h1, HVS_REG_FAULT, 32'h0000_0001);
        apb(1'h0, HVS_REG_FAULT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(offEvents, 0);
        apb(1'h1, HVS_REG_BAT_TIME, 32'h0000_0077);
        apb(1'h1, HVS_REG_IGN_TIME, 32'h0000_0077);
        fault_run(12'hB10, 12'h2EC, 12'h6EF, 12'h2EC, 0);
        fault_run(12'h250, 12'h2EC, 12'h352, 12'h2EC, 1);
        fault_run(12'h4B0, 12'h2B6, 12'h4B0, 12'h2BC, 2);
        // Every over-voltage code, under-voltage code at lowest level
        for (int c = 0; c < 16; c++) begin
            apb(1'h1, HVS_REG_BAT_THR, {24'h00_0000, 4'h5, 4'(c)});
            thr = HVS_OV_TAB[c];
            set_sense(thr, 12'h2EC);
            wait_for(0, 1'h0, 5, n);
            chk(n, 5);
            set_sense(thr + 12'h001 + 12'($random(seed) & 15), 12'h2EC);
            wait_for(0, 1'h0, 8, n);
            chk(n <= 5, 1'h1);
            set_sense(12'h2BC, 12'h2EC);
            wait_for(0, 1'h1, 60, n);
            chk(n < 60, 1'h1);
        end
        // Rising-edge mode ignores a falling ignition; battery inside defaults first
        set_sense(12'h4B0, 12'h2EC);
        apb(1'h1, HVS_REG_BAT_THR, 32'h0000_0000);
        apb(1'h1, HVS_REG_IGN_THR, 32'h0000_0090);
        apb(1'h0, HVS_REG_STATUS, 32'h0000_0000);
        chk(rd[7], 1'h1);
        set_sense(12'h4B0, 12'h100);
        wait_for(0, 1'h0, 40, n);
        chk(n, 40);
        chk(offEvents, 3);
        finish_test();
    end
endmodule // tb
